// ### fah_sensor.sv
/*
  sensor end: field alarm flags with hysteresis, emulated hall commutation
  outputs and the spi register port.
  assumes field strength in mT and a 16-bit angle arrive on the system clock;
  spi pins arrive asynchronously and are synchronised here.
*/
`timescale 1ns/1ps

// Contract
// (RQ1) 6 mT hysteresis on both field flags
// (RQ2) both threshold codes live in register 6
// (RQ3) low code bits 7:5, high 4:2
// (RQ4) code maps to listed rising/falling points
// (RQ5) each flag uses its own threshold independently
// (RQ6) status bits 7/6 also drive pins
// (RQ7) host read command: 010, address, zeros
// (RQ8) read data returns in the next frame
// (RQ9) sub-flags at bits 3,2; corrected low
// (RQ10) host tolerates short spurious low pulses
// (RQ11) host rereads a one after 2..100 us
// (RQ12) host may use inverted high flag
// (RQ13) three 50% outputs, 60 degrees apart; the code places them 120 electrical degrees apart
// (RQ14) angle split into steps by pole field
// (RQ15) code n gives 6(n+1) states
// (RQ16) angular hysteresis on commutation transitions
// (RQ17) one output changes per state boundary
module fah_sensor
  import fah_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // measurement
  input  wire logic [7:0]  fieldMt,
  input  wire logic [15:0] angle,
  // link
  fah_link_if.device       link
);

  fah_dev_s q;
  fah_dev_s d;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [7:0] riseMt(input logic [2:0] code);
    logic [7:0] v;
    v = 8'h00;
    unique case (code)
      3'h0: v = 8'd26;
      3'h1: v = 8'd41;
      3'h2: v = 8'd56;
      3'h3: v = 8'd70;
      3'h4: v = 8'd84;
      3'h5: v = 8'd98;
      3'h6: v = 8'd112;
      3'h7: v = 8'd126;
    endcase
    return v; // RQ4
  endfunction

  function automatic logic [7:0] fallMt(input logic [2:0] code);
    return riseMt(code) - `FAH_HYS_MT; // RQ1 RQ4
  endfunction

  function automatic logic [5:0] sectorOf(input logic [15:0] a, input logic [5:0] states);
    logic [21:0] p;
    p = a * states;
    return p[21:16]; // RQ14
  endfunction

  function automatic logic [2:0] uvwOf(input logic [5:0] s);
    logic [5:0] ph;
    logic [2:0] v;
    ph = 6'(s % `FAH_STATES_PER_PP);
    v = 3'h0;
    case (ph)
      6'h0: v = 3'b100;
      6'h1: v = 3'b110;
      6'h2: v = 3'b010;
      6'h3: v = 3'b011;
      6'h4: v = 3'b001;
      default: v = 3'b101;
    endcase
    return v; // RQ13 RQ17
  endfunction

  function automatic logic [7:0] regRead(input logic [4:0] a, input fah_dev_s s);
    logic [7:0] v;
    v = 8'h00;
    if (a == `FAH_REG_THR) begin
      v = s.cfgThr;
    end else if (a == `FAH_REG_POLE) begin
      v = {5'h00, s.cfgPole};
    end else if (a == `FAH_REG_STATUS) begin
      v[`FAH_ST_HIGH_BIT] = s.highFlag; // RQ6
      v[`FAH_ST_LOW_BIT] = s.lowFlag;
      v[`FAH_ST_SUBA_BIT] = s.subA; // RQ9
      v[`FAH_ST_SUBB_BIT] = s.subB;
    end
    return v;
  endfunction

  // ----------------------------------------
  // derived values
  // ----------------------------------------
  logic [2:0]  lowCode;
  logic [2:0]  highCode;
  logic [5:0]  states;
  logic [5:0]  secLo;
  logic [5:0]  secHi;
  logic        csActive;
  logic        sclkRise;
  logic        sclkFall;
  logic [2:0]  opcode;
  logic [4:0]  regAddr;

  assign lowCode  = q.cfgThr[`FAH_THR_LOW_MSB:`FAH_THR_LOW_LSB]; // RQ3
  assign highCode = q.cfgThr[`FAH_THR_HIGH_MSB:`FAH_THR_HIGH_LSB]; // RQ3
  assign states   = 6'(({3'h0, q.cfgPole} + 6'h01) * `FAH_STATES_PER_PP); // RQ15
  assign secLo    = sectorOf(16'(angle - `FAH_UVW_HYS), states); // RQ16
  assign secHi    = sectorOf(16'(angle + `FAH_UVW_HYS), states); // RQ16
  assign csActive = ~q.csSync[1];
  assign sclkRise = q.sclkSync[1] & ~q.sclkSync[2];
  assign sclkFall = ~q.sclkSync[1] & q.sclkSync[2];
  assign opcode   = q.shiftIn[15:13];
  assign regAddr  = q.shiftIn[12:8];

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    d = q;

    // pin synchronisers
    d.csSync   = {q.csSync[0], link.spiCsB};
    d.sclkSync = {q.sclkSync[1:0], link.spiSclk};
    d.mosiSync = {q.mosiSync[0], link.spiMosi};

    // field alarm flags
    if (!q.highFlag && fieldMt >= riseMt(highCode)) begin
      d.highFlag = 1'b1; // RQ1 RQ5
    end else if (q.highFlag && fieldMt < fallMt(highCode)) begin
      d.highFlag = 1'b0; // RQ1 RQ5
    end
    if (!q.lowFlag && fieldMt < fallMt(lowCode)) begin
      d.lowFlag = 1'b1; // RQ1 RQ5
    end else if (q.lowFlag && fieldMt >= riseMt(lowCode)) begin
      d.lowFlag = 1'b0; // RQ1 RQ5
    end
    d.subA = ~d.lowFlag; // RQ9
    d.subB = ~q.lowFlag; // RQ9

    // commutation, only when both hysteresis edges agree
    if (secLo == secHi && secLo != q.sector) begin
      d.sector = secLo; // RQ16
      d.hall_commutation_outputs = uvwOf(secLo); // RQ13 RQ17
    end

    // spi slave; misoOe doubles as third cs stage
    d.misoOe = csActive;
    if (csActive && !q.misoOe) begin
      d.bitCnt = 5'h00;
      d.miso = q.replyData[7]; // RQ8
      d.shiftOut = {q.replyData[6:0], 1'b0};
    end else if (csActive) begin
      if (sclkRise) begin
        d.shiftIn = {q.shiftIn[14:0], q.mosiSync[1]};
        d.bitCnt = q.bitCnt + 5'h01;
      end
      if (sclkFall && q.bitCnt < `FAH_REPLY_BITS) begin
        d.miso = q.shiftOut[7];
        d.shiftOut = {q.shiftOut[6:0], 1'b0};
      end
    end

    // frame end: decode the command
    if (!csActive && q.misoOe && q.bitCnt == `FAH_FRAME_BITS) begin
      if (opcode == `FAH_OP_READ) begin
        d.replyData = regRead(regAddr, q); // RQ7 RQ8
      end else if (opcode == `FAH_OP_WRITE) begin
        d.replyData = q.shiftIn[7:0];
        if (regAddr == `FAH_REG_THR) begin
          d.cfgThr = {q.shiftIn[7:2], 2'b00}; // RQ2 RQ3
        end else if (regAddr == `FAH_REG_POLE) begin
          d.cfgPole = q.shiftIn[2:0]; // RQ14
        end
      end
    end

    if (!rst_b) begin
      d = '0;
      d.csSync = 2'b11;
      d.cfgThr = `FAH_THR_RESET;
      d.cfgPole = `FAH_POLE_RESET;
      d.hall_commutation_outputs = uvwOf(6'h00);
      d.subA = 1'b1;
      d.subB = 1'b1;
      d.miso = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    q <= d;
  end

  // ----------------------------------------
  // pins
  // ----------------------------------------
  assign link.spiMisoOut   = q.miso;
  assign link.spiMisoOe    = q.misoOe;
  assign link.fieldHighFlag = q.highFlag; // RQ6
  assign link.fieldLowFlag  = q.lowFlag; // RQ6
  assign link.hallUvw       = q.hall_commutation_outputs; // RQ13

endmodule

// ### fah_consts.svh
/*
  constants of the field alarm and hall commutation link: register offsets,
  field positions, reset values, spi codes and timing counts.
  assumes a 100 mhz system clock shared by both ends.
*/
`ifndef FAH_CONSTS_SVH
`define FAH_CONSTS_SVH

// ----------------------------------------
// device register map
// ----------------------------------------
`define FAH_REG_THR        5'h06
`define FAH_REG_POLE       5'h07
`define FAH_REG_STATUS     5'h1b
`define FAH_THR_LOW_MSB    7
`define FAH_THR_LOW_LSB    5
`define FAH_THR_HIGH_MSB   4
`define FAH_THR_HIGH_LSB   2
`define FAH_ST_HIGH_BIT    7
`define FAH_ST_LOW_BIT     6
`define FAH_ST_SUBA_BIT    3
`define FAH_ST_SUBB_BIT    2
`define FAH_THR_RESET      8'h00
`define FAH_POLE_RESET     3'h0

// ----------------------------------------
// spi command frame
// ----------------------------------------
`define FAH_OP_READ        3'h2
`define FAH_OP_WRITE       3'h4
`define FAH_FRAME_BITS     5'h10
`define FAH_REPLY_BITS     5'h08

// ----------------------------------------
// field and angle figures
// ----------------------------------------
`define FAH_HYS_MT         8'h06
`define FAH_UVW_HYS        16'h0040
`define FAH_STATES_PER_PP  6'h06

// ----------------------------------------
// host register map (byte addresses)
// ----------------------------------------
`define FAH_H_CMD          8'h00
`define FAH_H_RX           8'h04
`define FAH_H_FLAGS        8'h08
`define FAH_H_IRQ_ST       8'h0c
`define FAH_H_IRQ_MASK     8'h10

// ----------------------------------------
// timing
// ----------------------------------------
`define FAH_CLK_MHZ        100
`define FAH_RECHECK_US     20
`define FAH_RECHECK_CYC    (`FAH_RECHECK_US * `FAH_CLK_MHZ)
`define FAH_SPI_HALF       8

`endif

// ### fah_pkg.sv
/*
  types of the field alarm and hall commutation link: state structs and
  the host spi sequencer states.
  assumes fah_consts.svh is on the include path.
*/
`include "fah_consts.svh"

package fah_pkg;

  // ----------------------------------------
  // host sequencer
  // ----------------------------------------
  typedef enum logic [2:0] {
    SPI_IDLE,
    SPI_LEAD,
    SPI_SHIFT,
    SPI_TRAIL,
    SPI_GAP
  } fah_spi_e;

  // ----------------------------------------
  // device state
  // ----------------------------------------
  typedef struct packed {
    logic [1:0]  csSync;
    logic [2:0]  sclkSync;
    logic [1:0]  mosiSync;
    logic [4:0]  bitCnt;
    logic [15:0] shiftIn;
    logic [7:0]  shiftOut;
    logic [7:0]  replyData;
    logic [7:0]  cfgThr;
    logic [2:0]  cfgPole;
    logic        highFlag;
    logic        lowFlag;
    logic        subA;
    logic        subB;
    logic [5:0]  sector;
    logic [2:0]  hall_commutation_outputs;
    logic        miso;
    logic        misoOe;
  } fah_dev_s;

  // ----------------------------------------
  // host state
  // ----------------------------------------
  typedef struct packed {
    logic        ack;
    logic [31:0] datR;
    fah_spi_e    st;
    logic [7:0]  div;
    logic [4:0]  bitIdx;
    logic [15:0] txSh;
    logic [15:0] cmdLast;
    logic        prevStatusRd;
    logic [7:0]  rx;
    logic        corrLow;
    logic        csB;
    logic        sclk;
    logic        mosi;
    logic [1:0]  misoSync;
    logic [1:0]  highSync;
    logic [1:0]  lowSync;
    logic [5:0]  uvwSync;
    logic [11:0] lowTmr;
    logic        lowFilt;
    logic [1:0]  irqSt;
    logic [1:0]  irqMask;
    logic        irq;
  } fah_host_s;

endpackage

// ### fah_link_if.sv
/*
  link between the sensor end and the controller end: spi pins, two field
  alarm pins and three commutation pins.
  assumes an idle-high miso line when the sensor does not drive it.
*/
`timescale 1ns/1ps

interface fah_link_if;
  // spi
  logic       spiCsB;
  logic       spiSclk;
  logic       spiMosi;
  logic       spiMisoOut;
  logic       spiMisoOe;
  logic       spiMisoLine;
  // alarm and commutation pins
  logic       fieldHighFlag;
  logic       fieldLowFlag;
  logic [2:0] hallUvw;

  // ----------------------------------------
  // wire level of the shared miso line
  // ----------------------------------------
  assign spiMisoLine = spiMisoOe ? spiMisoOut : 1'b1;

  modport device (
    input  spiCsB, spiSclk, spiMosi,
    output spiMisoOut, spiMisoOe, fieldHighFlag, fieldLowFlag, hallUvw
  );

  modport host (
    output spiCsB, spiSclk, spiMosi,
    input  spiMisoLine, fieldHighFlag, fieldLowFlag, hallUvw
  );
endinterface

// ### fah_controller.sv
/*
  controller end: spi master issuing 16-bit frames, flag pin sampling with
  reread filter, corrected low flag and a wishbone register port.
  assumes a classic wishbone master on the system clock.
*/
`timescale 1ns/1ps

module fah_controller
  import fah_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // wishbone slave
  input  wire logic        wbCyc,
  input  wire logic        wbStb,
  input  wire logic        wbWe,
  input  wire logic [7:0]  wbAdr,
  input  wire logic [3:0]  wbSel,
  input  wire logic [31:0] wbDatW,
  output logic      [31:0] wbDatR,
  output logic             wbAck,
  // interrupt
  output logic             irq,
  // link
  fah_link_if.host         link
);

  fah_host_s q;
  fah_host_s d;
  logic      req;
  logic      busy;
  logic      frameDone;

  assign req  = wbCyc & wbStb & ~q.ack;
  assign busy = (q.st != SPI_IDLE);

  function automatic logic [31:0] hostRead(input logic [7:0] a, input fah_host_s s, input logic b);
    logic [31:0] v;
    v = 32'h0;
    unique case (a)
      `FAH_H_CMD:      v = {15'h0, b, s.cmdLast};
      `FAH_H_RX:       v = {23'h0, s.corrLow, s.rx};
      `FAH_H_FLAGS:    v = {25'h0, s.uvwSync[5:3], ~s.highSync[1], s.lowFilt, s.lowSync[1], s.highSync[1]};
      `FAH_H_IRQ_ST:   v = {30'h0, s.irqSt};
      `FAH_H_IRQ_MASK: v = {30'h0, s.irqMask};
      default:         v = 32'h0;
    endcase
    return v;
  endfunction

  always_comb begin
    d = q;
    frameDone = 1'b0;

    // pin synchronisers
    d.misoSync = {q.misoSync[0], link.spiMisoLine};
    d.highSync = {q.highSync[0], link.fieldHighFlag};
    d.lowSync  = {q.lowSync[0], link.fieldLowFlag};
    d.uvwSync  = {q.uvwSync[2:0], link.hallUvw};

    // low flag reread filter
    if (!q.lowSync[1]) begin
      d.lowTmr = 12'h000;
      d.lowFilt = 1'b0; // RQ10 RQ11
    end else if (q.lowTmr != 12'(`FAH_RECHECK_CYC)) begin
      d.lowTmr = q.lowTmr + 12'h001;
    end else begin
      d.lowFilt = 1'b1; // RQ11
    end

    // spi sequencer
    d.div = q.div + 8'h01;
    unique case (q.st)
      SPI_IDLE: begin
        d.div = 8'h00;
        if (req && wbWe && wbAdr == `FAH_H_CMD && wbSel[1:0] == 2'b11) begin
          d.cmdLast = wbDatW[15:0];
          d.txSh = {wbDatW[14:0], 1'b0};
          d.mosi = wbDatW[15];
          d.csB = 1'b0;
          d.bitIdx = 5'h00;
          d.st = SPI_LEAD;
        end
      end
      SPI_LEAD: begin
        if (q.div == 8'(`FAH_SPI_HALF - 1)) begin
          d.div = 8'h00;
          d.sclk = 1'b1;
          d.st = SPI_SHIFT;
        end
      end
      SPI_SHIFT: begin
        if (q.div == 8'(`FAH_SPI_HALF - 1)) begin
          d.div = 8'h00;
          d.sclk = ~q.sclk;
          if (q.sclk) begin
            if (q.bitIdx < `FAH_REPLY_BITS) begin
              d.rx = {q.rx[6:0], q.misoSync[1]};
            end
            d.mosi = q.txSh[15];
            d.txSh = {q.txSh[14:0], 1'b0};
            d.bitIdx = q.bitIdx + 5'h01;
            if (q.bitIdx == `FAH_FRAME_BITS - 5'h01) begin
              d.st = SPI_TRAIL;
            end
          end
        end
      end
      SPI_TRAIL: begin
        if (q.div == 8'(`FAH_SPI_HALF - 1)) begin
          d.div = 8'h00;
          d.csB = 1'b1;
          d.st = SPI_GAP;
          frameDone = 1'b1;
          if (q.prevStatusRd) begin
            d.corrLow = ~(q.rx[`FAH_ST_SUBA_BIT] | q.rx[`FAH_ST_SUBB_BIT]); // RQ9
          end
          d.prevStatusRd = (q.cmdLast[15:13] == `FAH_OP_READ) && (q.cmdLast[12:8] == `FAH_REG_STATUS); // RQ7 RQ8
        end
      end
      SPI_GAP: begin
        if (q.div == 8'(`FAH_SPI_HALF - 1)) begin
          d.st = SPI_IDLE;
        end
      end
    endcase

    // wishbone answer, one cycle after the request
    d.ack = req;
    if (req) begin
      d.datR = hostRead(wbAdr, q, busy);
      if (wbWe && wbSel[0] && wbAdr == `FAH_H_IRQ_MASK) begin
        d.irqMask = wbDatW[1:0];
      end
    end

    // interrupts: set wins over write-one clear
    if (req && wbWe && wbSel[0] && wbAdr == `FAH_H_IRQ_ST) begin
      d.irqSt = q.irqSt & ~wbDatW[1:0];
    end
    if (frameDone) begin
      d.irqSt[0] = 1'b1;
    end
    if (d.lowFilt != q.lowFilt) begin
      d.irqSt[1] = 1'b1;
    end
    d.irq = |(d.irqSt & d.irqMask);

    if (!rst_b) begin
      d = '0;
      d.st = SPI_IDLE;
      d.csB = 1'b1;
      d.misoSync = 2'b11;
    end
  end

  always_ff @(posedge clk) begin
    q <= d;
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign wbDatR       = q.datR;
  assign wbAck        = q.ack;
  assign irq          = q.irq;
  assign link.spiCsB  = q.csB;
  assign link.spiSclk = q.sclk;
  assign link.spiMosi = q.mosi;

endmodule

// ### fah_link_props.sv
/*
  assertions on the link between sensor and controller ends.
  assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/1ps

module fah_link_props (
  // clock and reset
  input wire logic       clk,
  input wire logic       rst_b,
  // link
  input wire logic       spiCsB,
  input wire logic       spiSclk,
  input wire logic       spiMosi,
  input wire logic       spiMisoOe,
  input wire logic [2:0] hallUvw
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  // ----------------------------------------
  // commutation pins
  // ----------------------------------------
  property p_uvw_step;
    $changed(hallUvw) |-> $countones(hallUvw ^ $past(hallUvw)) == 1;
  endproperty
  a_uvw_step: assert property (p_uvw_step) else $error("uvw moved two lines");
  property p_uvw_mix;
    hallUvw != 3'h0 && hallUvw != 3'h7;
  endproperty
  a_uvw_mix: assert property (p_uvw_mix) else $error("uvw all equal");

  // ----------------------------------------
  // spi framing
  // ----------------------------------------
  property p_cs_lead;
    $fell(spiCsB) |-> !spiSclk [*8];
  endproperty
  a_cs_lead: assert property (p_cs_lead) else $error("sclk too soon");
  property p_sclk_half;
    $rose(spiSclk) |-> spiSclk [*8] ##1 !spiSclk;
  endproperty
  a_sclk_half: assert property (p_sclk_half) else $error("sclk high phase");
  property p_mosi_hold;
    spiSclk && $past(spiSclk) |-> $stable(spiMosi);
  endproperty
  a_mosi_hold: assert property (p_mosi_hold) else $error("mosi moved");
  property p_idle;
    spiCsB |-> !spiSclk;
  endproperty
  a_idle: assert property (p_idle) else $error("sclk outside frame");
  property p_oe_on;
    $fell(spiCsB) |-> ##[1:4] spiMisoOe;
  endproperty
  a_oe_on: assert property (p_oe_on) else $error("miso not driven");
  property p_oe_off;
    $rose(spiCsB) |-> ##[1:4] !spiMisoOe;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("miso not released");
  property p_gap;
    $rose(spiCsB) |-> spiCsB [*8];
  endproperty
  a_gap: assert property (p_gap) else $error("frame gap short");
endmodule

// ### fah_tb.sv
/*
  testbench: both ends joined by the link, driven over wishbone and the
  sensor's field and angle inputs.
  assumes fah_pkg.sv and fah_consts.svh compiled first.
*/
`timescale 1ns/1ps
`include "fah_consts.svh"

module tb;
  logic        clk;
  logic        rst_b;
  logic        wbCyc;
  logic        wbStb;
  logic        wbWe;
  logic [7:0]  wbAdr;
  logic [3:0]  wbSel;
  logic [31:0] wbDatW;
  logic [31:0] wbDatR;
  logic        wbAck;
  logic        irq;
  logic [7:0]  fieldMt;
  logic [15:0] angle;
  int          failCount;
  int          testsRun;

  fah_link_if link();
  fah_sensor u_fah_sensor (.clk(clk), .rst_b(rst_b), .fieldMt(fieldMt), .angle(angle), .link(link.device));
  fah_controller u_fah_controller (.clk(clk), .rst_b(rst_b), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe),
    .wbAdr(wbAdr), .wbSel(wbSel), .wbDatW(wbDatW), .wbDatR(wbDatR), .wbAck(wbAck), .irq(irq),
    .link(link.host));
  fah_link_props u_fah_link_props (.clk(clk), .rst_b(rst_b), .spiCsB(link.spiCsB), .spiSclk(link.spiSclk),
    .spiMosi(link.spiMosi), .spiMisoOe(link.spiMisoOe), .hallUvw(link.hallUvw));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    testsRun++;
    if (got !== exp) begin
      failCount++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", testsRun, failCount);
    if (failCount == 0 && testsRun > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= a;
    wbDatW <= d;
    do @(posedge clk); while (wbAck !== 1'b1);
    r = wbDatR;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    @(posedge clk);
  endtask

  task automatic spi(input logic [15:0] f, output logic [7:0] rx);
    logic [31:0] r;
    wb(1'b1, `FAH_H_CMD, {16'h0000, f}, r);
    do wb(1'b0, `FAH_H_CMD, 32'h0, r); while (r[16] !== 1'b0);
    wb(1'b0, `FAH_H_RX, 32'h0, r);
    rx = r[7:0];
  endtask

  task automatic wreg(input logic [4:0] a, input logic [7:0] d);
    logic [7:0] v;
    spi({3'h4, a, d}, v);
  endtask

  task automatic rreg(input logic [4:0] a, output logic [7:0] v);
    spi({3'h2, a, 8'h00}, v);
    spi({3'h2, a, 8'h00}, v);
  endtask

  task automatic fld(input logic [7:0] f, input logic h, input logic l);
    fieldMt <= f;
    repeat (3) @(posedge clk);
    chk({link.fieldHighFlag, link.fieldLowFlag}, {h, l});
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_regs;
    logic [7:0]  v;
    logic [31:0] r;
    wreg(`FAH_REG_THR, 8'ha7);
    wreg(`FAH_REG_POLE, 8'h05);
    spi({3'h2, `FAH_REG_THR, 8'h00}, v);
    spi({3'h2, `FAH_REG_POLE, 8'h00}, v);
    chk(v, 8'ha4);
    spi({3'h2, `FAH_REG_THR, 8'h00}, v);
    chk(v & 8'h07, 8'h05);
    wb(1'b0, 8'h20, 32'h0, r);
    chk(r, 32'h0);
  endtask

  task automatic t_thr;
    logic [7:0] rise[8] = '{8'h1a, 8'h29, 8'h38, 8'h46, 8'h54, 8'h62, 8'h70, 8'h7e};
    logic [7:0] fall[8] = '{8'h14, 8'h23, 8'h32, 8'h40, 8'h4e, 8'h5c, 8'h6a, 8'h78};
    for (int c = 0; c < 8; c++) begin
      wreg(`FAH_REG_THR, {3'(c), 3'(c), 2'h0});
      fld(fall[c] - 8'h01, 1'b0, 1'b1);
      fld(rise[c] - 8'h01, 1'b0, 1'b1);
      fld(rise[c], 1'b1, 1'b0);
      fld(fall[c], 1'b1, 1'b0);
      fld(fall[c] - 8'h01, 1'b0, 1'b1);
    end
  endtask

  task automatic t_status;
    logic [7:0]  v;
    logic [31:0] r;
    wreg(`FAH_REG_THR, 8'h64);
    fld(8'h32, 1'b1, 1'b1);
    rreg(`FAH_REG_STATUS, v);
    chk(v & 8'hcc, 8'hc0);
    wb(1'b0, `FAH_H_RX, 32'h0, r);
    chk(r[8], 1'b1);
    fld(8'h50, 1'b1, 1'b0);
    rreg(`FAH_REG_STATUS, v);
    chk(v & 8'hcc, 8'h8c);
    wb(1'b0, `FAH_H_RX, 32'h0, r);
    chk(r[8], 1'b0);
    wb(1'b0, `FAH_H_FLAGS, 32'h0, r);
    chk(r[3:0], 4'h1);
  endtask

  task automatic t_glitch;
    logic [31:0] r;
    fieldMt <= 8'h3c;
    repeat (150) @(posedge clk);
    wb(1'b0, `FAH_H_FLAGS, 32'h0, r);
    chk(r[2:1], 2'h1);
    fieldMt <= 8'h50;
    repeat (2100) @(posedge clk);
    wb(1'b0, `FAH_H_FLAGS, 32'h0, r);
    chk(r[2:1], 2'h0);
    fieldMt <= 8'h3c;
    repeat (2100) @(posedge clk);
    wb(1'b0, `FAH_H_FLAGS, 32'h0, r);
    chk(r[2:1], 2'h3);
  endtask

  task automatic t_irq;
    logic [31:0] r;
    logic [7:0]  v;
    wb(1'b1, `FAH_H_IRQ_MASK, 32'h0, r);
    wb(1'b1, `FAH_H_IRQ_ST, 32'h3, r);
    spi({3'h2, `FAH_REG_STATUS, 8'h00}, v);
    wb(1'b0, `FAH_H_IRQ_ST, 32'h0, r);
    chk(r[0], 1'b1);
    chk(irq, 1'b0);
    wb(1'b1, `FAH_H_IRQ_MASK, 32'h1, r);
    repeat (2) @(posedge clk);
    chk(irq, 1'b1);
    wb(1'b1, `FAH_H_IRQ_ST, 32'h1, r);
    repeat (2) @(posedge clk);
    chk(irq, 1'b0);
  endtask

  task automatic t_uvw;
    logic [2:0] prev;
    int         changes;
    int         ones;
    for (int p = 0; p < 8; p++) begin
      wreg(`FAH_REG_POLE, 8'(p));
      angle <= 16'h0080;
      repeat (4) @(posedge clk);
      prev = link.hallUvw;
      changes = 0;
      ones = 0;
      for (int i = 1; i <= 512; i++) begin
        angle <= 16'(16'h0080 + i * 128);
        repeat (2) @(posedge clk);
        if (link.hallUvw !== prev) changes++;
        if (link.hallUvw[2] === 1'b1) ones++;
        prev = link.hallUvw;
      end
      chk(changes, 6 * (p + 1));
      chk(ones >= 252 - 2 * p && ones <= 260 + 2 * p, 1'b1);
    end
    wreg(`FAH_REG_POLE, 8'h00);
    angle <= 16'h2a00;
    repeat (4) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      angle <= i[0] ? 16'h2acb : 16'h2a8b;
      repeat (2) @(posedge clk);
      chk(link.hallUvw, 3'b100);
    end
    angle <= 16'h2b40;
    repeat (2) @(posedge clk);
    chk(link.hallUvw, 3'b110);
  endtask

  // ----------------------------------------
  // clock, watchdog and sequence
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    repeat (40000) @(posedge clk);
    failCount++;
    results();
  end

  initial begin
    rst_b = 1'b0;
    wbCyc = 1'b0;
    wbStb = 1'b0;
    wbWe = 1'b0;
    wbAdr = 8'h00;
    wbSel = 4'hf;
    wbDatW = 32'h0;
    fieldMt = 8'h00;
    angle = 16'h0080;
    failCount = 0;
    testsRun = 0;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    t_regs();
    t_thr();
    t_status();
    t_glitch();
    t_irq();
    t_uvw();
    results();
  end
endmodule
